/* hw/spi_prog_regs.svh */
`ifndef SPI_PROG_REGS_SVH
`define SPI_PROG_REGS_SVH
// How it works
// - While an EEPROM byte is being programmed, reading that address returns FF.
// - After the self-timed write ends, reads return the newly written value.
// - AC 53 xx xx enables programming, accepted only while reset pin is low.
// - AC then 100x xxxx erases EEPROM and program memory.
// - 0010 H000 reads program memory byte at six plus eight address bits.
// - 0100 H000 loads page buffer word offset; low byte before high byte.
// - 4C commits page buffer; page from byte two low six and byte three top two.
// - A0 reads EEPROM at two plus eight address bits, data in byte four.
// - C0 writes byte four into EEPROM, same address layout as a read.
// - 58 00 reads lock bits in low six; AC 111x writes them from byte four.
// - AC A0 writes low fuse, AC A8 writes high fuse from byte four.
// - 50 00 reads low fuse, 58 08 reads high fuse in byte four.
// - Input bits sampled on rising link clock, output changes on falling edge.
// - Second enable byte echoes back during third byte; programmer sends all four.
// - Each EEPROM byte write erases and writes in one self-timed operation.
`define CORE_CLK_PERIOD_NS 20.0
`define PAGE_WRITE_WAIT_MS 4.5
`define EEPROM_BYTE_WAIT_MS 9.0
`define ERASE_WAIT_MS 9.0
`define FLASH_AW 14
`define PAGE_AW 6
`define EE_AW 10
`define BUSY_W 20
`define BIT_LAST 5'h1F
`define BYTE3_DONE 5'h18
`define OP_MEM_ACCESS 8'hAC
`define OP_ENABLE_KEY 8'h53
`define OP_ERASE_KEY 3'h4
`define OP_LOCK_KEY 3'h7
`define OP_FUSE_LO_KEY 8'hA0
`define OP_FUSE_HI_KEY 8'hA8
`define OP_RD_FLASH 4'h2
`define OP_LD_PAGE 4'h4
`define OP_WR_PAGE 8'h4C
`define OP_RD_EE 8'hA0
`define OP_WR_EE 8'hC0
`define OP_RD_LOCK 8'h58
`define OP_RD_FUSE_LO 8'h50
`define OP_RD_SIG 8'h30
`define OP_RD_CAL 8'h38
`define B2_ZERO 8'h00
`define B2_FUSE_HI 8'h08
`define ERASED_BYTE 8'hFF
`define ERASED_WORD 16'hFFFF
`define LOCK_PAD 2'h3
`define LOCK_RESET 6'h3F
`endif

/* hw/spi_prog_pkg.sv */
`include "spi_prog_regs.svh"
package spi_prog_pkg;
  typedef enum logic [1:0] {SW_IDLE, SW_ERASE, SW_PAGE} sweep_t;
  typedef enum logic [1:0] {BUSY_NONE, BUSY_PAGE, BUSY_EE, BUSY_ERASE} busy_t;
  typedef enum logic [3:0] {
    CMD_NONE, CMD_ENABLE, CMD_ERASE, CMD_RD_FLASH, CMD_LD_PAGE, CMD_WR_PAGE,
    CMD_RD_EE, CMD_WR_EE, CMD_RD_LOCK, CMD_WR_LOCK, CMD_RD_SIG, CMD_WR_FUSE_LO,
    CMD_WR_FUSE_HI, CMD_RD_FUSE_LO, CMD_RD_FUSE_HI, CMD_RD_CAL
  } cmd_t;
  typedef struct packed {
    logic                   sck_s1;
    logic                   sck_s2;
    logic                   sck_q;
    logic                   mosi_s1;
    logic                   mosi_s2;
    logic                   rst_s1;
    logic                   rst_s2;
    logic                   enabled;
    logic                   miso;
    logic                   busy;
    logic [4:0]             bit_cnt;
    logic [31:0]            rx;
    logic [7:0]             tx;
    sweep_t                 sweep;
    logic [`FLASH_AW-1:0]   idx;
    busy_t                  busy_kind;
    logic [`BUSY_W-1:0]     busy_cnt;
    logic [`FLASH_AW-`PAGE_AW-1:0] busy_page;
    logic [`EE_AW-1:0]      busy_ee;
    logic [5:0]             lock;
    logic [7:0]             fuse_lo;
    logic [7:0]             fuse_hi;
  } state_t;
endpackage

/* hw/serial_program_cmd_decoder.sv */
`timescale 1ns/1ns
`include "spi_prog_regs.svh"
module serial_program_cmd_decoder #(
  parameter int          PAGE_WAIT_CYC  = int'($ceil(`PAGE_WRITE_WAIT_MS * 1.0E6 / `CORE_CLK_PERIOD_NS)),
  parameter int          EE_WAIT_CYC    = int'($ceil(`EEPROM_BYTE_WAIT_MS * 1.0E6 / `CORE_CLK_PERIOD_NS)),
  parameter int          ERASE_WAIT_CYC = int'($ceil(`ERASE_WAIT_MS * 1.0E6 / `CORE_CLK_PERIOD_NS)),
  // Arbitrary identity values.
  parameter logic [31:0] SIGNATURE      = 32'h0012_3456,
  parameter logic [7:0]  CAL_BYTE       = 8'h80,
  parameter logic [7:0]  FUSE_LO_INIT   = 8'hE1,
  parameter logic [7:0]  FUSE_HI_INIT   = 8'h99
) (
  // Clock and reset.
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Programming link pins.
  input  wire logic prog_reset_n_i,
  input  wire logic sck_i,
  input  wire logic mosi_i,
  output logic      miso_o,
  // Status.
  output logic      prog_enabled_o,
  output logic      busy_o
);

  localparam int FLASH_WORDS = 2 ** `FLASH_AW;
  localparam int PAGE_WORDS  = 2 ** `PAGE_AW;
  localparam int EE_BYTES    = 2 ** `EE_AW;

  if (PAGE_WAIT_CYC < PAGE_WORDS || EE_WAIT_CYC < 1 || ERASE_WAIT_CYC < FLASH_WORDS ||
      PAGE_WAIT_CYC >= 2 ** `BUSY_W || EE_WAIT_CYC >= 2 ** `BUSY_W || ERASE_WAIT_CYC >= 2 ** `BUSY_W) begin : g_bad
    $error("Wait counts do not fit the busy timer or are shorter than the memory sweep.");
  end

  localparam spi_prog_pkg::state_t S_RST = '{
    rst_s1: 1'b1, rst_s2: 1'b1, sweep: spi_prog_pkg::SW_IDLE, busy_kind: spi_prog_pkg::BUSY_NONE,
    lock: `LOCK_RESET, fuse_lo: FUSE_LO_INIT, fuse_hi: FUSE_HI_INIT, default: '0};

  logic [15:0]                  flash   [FLASH_WORDS];
  logic [7:0]                   ee      [EE_BYTES];
  logic [7:0]                   pbuf_lo [PAGE_WORDS];
  logic [7:0]                   pbuf_hi [PAGE_WORDS];

  spi_prog_pkg::state_t         s;
  spi_prog_pkg::state_t         next_s;
  spi_prog_pkg::cmd_t           cmd_rd;
  spi_prog_pkg::cmd_t           cmd_ex;
  logic                         rise;
  logic                         fall;
  logic                         exec;
  logic                         wr_ok;
  logic [31:0]                  nrx;
  logic [4:0]                   ncnt;
  logic [7:0]                   rd_byte;
  logic [`FLASH_AW-1:0]         rd_fa;
  logic [`EE_AW-1:0]            rd_ea;
  logic                         ee_hit;
  logic                         fl_hit;
  logic                         ee_we;
  logic [`EE_AW-1:0]            ee_addr;
  logic [7:0]                   ee_data;
  logic                         pl_we;
  logic                         pl_hi;
  logic [`PAGE_AW-1:0]          pl_idx;
  logic [7:0]                   pl_data;

  // Maps the first two instruction bytes onto a command.
  function automatic spi_prog_pkg::cmd_t decode(input logic [7:0] b1, input logic [7:0] b2);
    decode = spi_prog_pkg::CMD_NONE;
    if (b1 == `OP_MEM_ACCESS) begin
      if (b2 == `OP_ENABLE_KEY) decode = spi_prog_pkg::CMD_ENABLE;
      else if (b2[7:5] == `OP_ERASE_KEY) decode = spi_prog_pkg::CMD_ERASE;
      else if (b2[7:5] == `OP_LOCK_KEY) decode = spi_prog_pkg::CMD_WR_LOCK;
      else if (b2 == `OP_FUSE_LO_KEY) decode = spi_prog_pkg::CMD_WR_FUSE_LO;
      else if (b2 == `OP_FUSE_HI_KEY) decode = spi_prog_pkg::CMD_WR_FUSE_HI;
    end else if (b1[7:4] == `OP_RD_FLASH && b1[2:0] == '0) begin
      decode = spi_prog_pkg::CMD_RD_FLASH;
    end else if (b1 == `OP_WR_PAGE) begin
      decode = spi_prog_pkg::CMD_WR_PAGE;
    end else if (b1[7:4] == `OP_LD_PAGE && b1[2:0] == '0) begin
      decode = spi_prog_pkg::CMD_LD_PAGE;
    end else if (b1 == `OP_RD_EE) begin
      decode = spi_prog_pkg::CMD_RD_EE;
    end else if (b1 == `OP_WR_EE) begin
      decode = spi_prog_pkg::CMD_WR_EE;
    end else if (b1 == `OP_RD_LOCK && b2 == `B2_ZERO) begin
      decode = spi_prog_pkg::CMD_RD_LOCK;
    end else if (b1 == `OP_RD_LOCK && b2 == `B2_FUSE_HI) begin
      decode = spi_prog_pkg::CMD_RD_FUSE_HI;
    end else if (b1 == `OP_RD_FUSE_LO && b2 == `B2_ZERO) begin
      decode = spi_prog_pkg::CMD_RD_FUSE_LO;
    end else if (b1 == `OP_RD_SIG) begin
      decode = spi_prog_pkg::CMD_RD_SIG;
    end else if (b1 == `OP_RD_CAL) begin
      decode = spi_prog_pkg::CMD_RD_CAL;
    end
  endfunction

  assign rise   = s.sck_s2 && !s.sck_q;
  assign fall   = !s.sck_s2 && s.sck_q;
  assign nrx    = {s.rx[30:0], s.mosi_s2};
  assign ncnt   = s.bit_cnt + 5'h01;
  assign exec   = rise && !s.rst_s2 && s.bit_cnt == `BIT_LAST;
  assign wr_ok  = s.enabled && s.busy_kind == spi_prog_pkg::BUSY_NONE;
  assign cmd_rd = decode(nrx[23:16], nrx[15:8]);
  assign cmd_ex = decode(nrx[31:24], nrx[23:16]);
  assign rd_fa  = {nrx[13:8], nrx[7:0]};
  assign rd_ea  = {nrx[9:8], nrx[7:0]};
  assign fl_hit = s.busy_kind == spi_prog_pkg::BUSY_ERASE ||
                  (s.busy_kind == spi_prog_pkg::BUSY_PAGE && rd_fa[`FLASH_AW-1:`PAGE_AW] == s.busy_page);
  assign ee_hit = s.busy_kind == spi_prog_pkg::BUSY_ERASE ||
                  (s.busy_kind == spi_prog_pkg::BUSY_EE && rd_ea == s.busy_ee);

  // Byte returned during the fourth instruction byte.
  always_comb begin
    rd_byte = '0;
    if (s.enabled) begin
      case (cmd_rd)
        spi_prog_pkg::CMD_RD_FLASH: rd_byte = fl_hit ? `ERASED_BYTE :
                                    nrx[19] ? flash[rd_fa][15:8] : flash[rd_fa][7:0];
        spi_prog_pkg::CMD_RD_EE: rd_byte = ee_hit ? `ERASED_BYTE : ee[rd_ea];
        spi_prog_pkg::CMD_RD_LOCK: rd_byte = {`LOCK_PAD, s.lock};
        spi_prog_pkg::CMD_RD_FUSE_LO: rd_byte = s.fuse_lo;
        spi_prog_pkg::CMD_RD_FUSE_HI: rd_byte = s.fuse_hi;
        spi_prog_pkg::CMD_RD_SIG: rd_byte = SIGNATURE[{nrx[1:0], 3'h0} +: 8];
        spi_prog_pkg::CMD_RD_CAL: rd_byte = CAL_BYTE;
        default: rd_byte = '0;
      endcase
    end
  end

  always_comb begin
    next_s         = s;
    ee_we          = 1'b0;
    ee_addr        = '0;
    ee_data        = '0;
    pl_we          = 1'b0;
    pl_hi          = 1'b0;
    pl_idx         = '0;
    pl_data        = '0;
    next_s.sck_s1  = sck_i;
    next_s.sck_s2  = s.sck_s1;
    next_s.sck_q   = s.sck_s2;
    next_s.mosi_s1 = mosi_i;
    next_s.mosi_s2 = s.mosi_s1;
    next_s.rst_s1  = prog_reset_n_i;
    next_s.rst_s2  = s.rst_s1;
    // Self-timed wait; the busy address reads FF until it expires.
    if (s.busy_cnt != '0) begin
      next_s.busy_cnt = s.busy_cnt - `BUSY_W'(1);
      if (s.busy_cnt == `BUSY_W'(1)) begin
        next_s.busy_kind = spi_prog_pkg::BUSY_NONE;
        next_s.busy      = 1'b0;
      end
    end
    case (s.sweep)
      spi_prog_pkg::SW_ERASE: begin
        next_s.idx = s.idx + `FLASH_AW'(1);
        if (&s.idx) begin
          next_s.sweep = spi_prog_pkg::SW_IDLE;
        end
      end
      spi_prog_pkg::SW_PAGE: begin
        next_s.idx = s.idx + `FLASH_AW'(1);
        if (&s.idx[`PAGE_AW-1:0]) begin
          next_s.sweep = spi_prog_pkg::SW_IDLE;
        end
      end
      default: next_s.sweep = spi_prog_pkg::SW_IDLE;
    endcase
    if (s.rst_s2) begin
      next_s.enabled = 1'b0;
      next_s.bit_cnt = '0;
      next_s.tx      = '0;
      next_s.miso    = 1'b0;
    end else begin
      if (rise) begin
        next_s.rx      = nrx;
        next_s.bit_cnt = ncnt;
        if (ncnt[2:0] == 3'h0) begin
          next_s.tx = (ncnt == `BYTE3_DONE) ? rd_byte : nrx[7:0];
        end
      end
      if (fall) begin
        next_s.miso = s.tx[7];
        next_s.tx   = {s.tx[6:0], 1'b0};
      end
      if (exec) begin
        case (cmd_ex)
          spi_prog_pkg::CMD_ENABLE: next_s.enabled = 1'b1;
          spi_prog_pkg::CMD_ERASE: begin
            if (wr_ok) begin
              next_s.sweep     = spi_prog_pkg::SW_ERASE;
              next_s.idx       = '0;
              next_s.busy_kind = spi_prog_pkg::BUSY_ERASE;
              next_s.busy_cnt  = `BUSY_W'(ERASE_WAIT_CYC);
              next_s.busy      = 1'b1;
            end
          end
          spi_prog_pkg::CMD_LD_PAGE: begin
            if (wr_ok) begin
              pl_we   = 1'b1;
              pl_hi   = nrx[27];
              pl_idx  = nrx[13:8];
              pl_data = nrx[7:0];
            end
          end
          spi_prog_pkg::CMD_WR_PAGE: begin
            if (wr_ok) begin
              next_s.sweep     = spi_prog_pkg::SW_PAGE;
              next_s.idx       = '0;
              next_s.busy_page = {nrx[21:16], nrx[15:14]};
              next_s.busy_kind = spi_prog_pkg::BUSY_PAGE;
              next_s.busy_cnt  = `BUSY_W'(PAGE_WAIT_CYC);
              next_s.busy      = 1'b1;
            end
          end
          spi_prog_pkg::CMD_WR_EE: begin
            if (wr_ok) begin
              ee_we            = 1'b1;
              ee_addr          = {nrx[17:16], nrx[15:8]};
              ee_data          = nrx[7:0];
              next_s.busy_ee   = {nrx[17:16], nrx[15:8]};
              next_s.busy_kind = spi_prog_pkg::BUSY_EE;
              next_s.busy_cnt  = `BUSY_W'(EE_WAIT_CYC);
              next_s.busy      = 1'b1;
            end
          end
          spi_prog_pkg::CMD_WR_LOCK: begin
            if (s.enabled) next_s.lock = nrx[5:0];
          end
          spi_prog_pkg::CMD_WR_FUSE_LO: begin
            if (s.enabled) next_s.fuse_lo = nrx[7:0];
          end
          spi_prog_pkg::CMD_WR_FUSE_HI: begin
            if (s.enabled) next_s.fuse_hi = nrx[7:0];
          end
          default: next_s.enabled = s.enabled;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= S_RST;
    end else begin
      s <= next_s;
    end
  end

  // Memory arrays; the erase sweep clears both arrays one word per cycle.
  always_ff @(posedge core_clk_i) begin
    if (s.sweep == spi_prog_pkg::SW_ERASE) begin
      flash[s.idx] <= `ERASED_WORD;
      if (s.idx < `FLASH_AW'(EE_BYTES)) begin
        ee[s.idx[`EE_AW-1:0]] <= `ERASED_BYTE;
      end
    end else if (s.sweep == spi_prog_pkg::SW_PAGE) begin
      flash[{s.busy_page, s.idx[`PAGE_AW-1:0]}] <= {pbuf_hi[s.idx[`PAGE_AW-1:0]], pbuf_lo[s.idx[`PAGE_AW-1:0]]};
    end
    if (ee_we) begin
      ee[ee_addr] <= ee_data;
    end
    if (pl_we && pl_hi) begin
      pbuf_hi[pl_idx] <= pl_data;
    end
    if (pl_we && !pl_hi) begin
      pbuf_lo[pl_idx] <= pl_data;
    end
  end

  assign miso_o         = s.miso;
  assign prog_enabled_o = s.enabled;
  assign busy_o         = s.busy;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_ee_poll_ff: assert property (
    rise && !s.rst_s2 && ncnt == `BYTE3_DONE && s.enabled && cmd_rd == spi_prog_pkg::CMD_RD_EE && ee_hit
    |=> s.tx == `ERASED_BYTE) else $error("Busy EEPROM address did not read FF.");
  chk_busy_ends: assert property (
    s.busy_kind != spi_prog_pkg::BUSY_NONE && s.busy_cnt == `BUSY_W'(1)
    |=> s.busy_kind == spi_prog_pkg::BUSY_NONE && !busy_o) else $error("Busy state did not end on time.");
  chk_enable_cmd: assert property (
    exec && cmd_ex == spi_prog_pkg::CMD_ENABLE |=> prog_enabled_o) else $error("Enable not accepted.");
  chk_enable_drop: assert property (
    s.rst_s2 |=> !prog_enabled_o) else $error("Enable held while reset pin high.");
  chk_erase_start: assert property (
    exec && wr_ok && cmd_ex == spi_prog_pkg::CMD_ERASE
    |=> s.sweep == spi_prog_pkg::SW_ERASE && s.idx == '0 && busy_o) else $error("Erase did not start.");
  chk_ee_write: assert property (
    ee_we |=> ee[$past(ee_addr)] == $past(ee_data)) else $error("EEPROM byte not stored.");
  chk_no_op_off: assert property (
    !s.enabled |-> !ee_we && !pl_we && $stable(s.lock)) else $error("Memory action before enabling.");
  chk_echo_byte: assert property (
    rise && !s.rst_s2 && s.bit_cnt == 5'h0F |=> s.tx == s.rx[7:0]) else $error("Second byte not echoed.");
  chk_miso_fall: assert property (
    $changed(miso_o) && !$past(s.rst_s2) |-> $past(fall)) else $error("Output changed off falling edge.");
  chk_fuse_hi: assert property (
    exec && s.enabled && cmd_ex == spi_prog_pkg::CMD_WR_FUSE_HI
    |=> s.fuse_hi == $past(nrx[7:0])) else $error("High fuse not written.");

  cov_enable: cover property (exec && cmd_ex == spi_prog_pkg::CMD_ENABLE);
  cov_page_write: cover property (s.sweep == spi_prog_pkg::SW_PAGE ##1 s.sweep == spi_prog_pkg::SW_IDLE);
  cov_ee_write: cover property (ee_we);
  cov_erase: cover property (s.busy_kind == spi_prog_pkg::BUSY_ERASE);

endmodule

/* verification/isp_programmer.sv */
`timescale 1ns/1ns
module isp_programmer (
  // Link pins toward the device.
  output logic      sck_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  localparam int HALF_NS = 80;

  initial begin
    sck_o  = 1'b0;
    mosi_o = 1'b0;
  end

  // Shifts one whole instruction MSB first and collects the answer bits.
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      mosi_o = cmd[i];
      #HALF_NS sck_o = 1'b1;
      #(HALF_NS - 1) rsp[i] = miso_i;
      #1 sck_o = 1'b0;
    end
    #HALF_NS mosi_o = ~mosi_o;
  endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ns
`define CHECK_EQ(act, exp, msg) \
  begin check_count++; if ((act) !== (exp)) begin failures++; \
  $display("[FAIL] %0t %s got %h want %h", $time, msg, act, exp); end end
module tb;
  logic core_clk;
  logic rst_n;
  logic prog_reset_n;
  logic sck;
  logic mosi;
  logic miso;
  logic prog_enabled;
  logic busy;
  int   failures;
  int   check_count;
  localparam int          EE_WAIT = 600;
  // Arbitrary identity values.
  localparam logic [31:0] SIG     = 32'h5A6B_7C8D;
  localparam logic [7:0]  CAL     = 8'h4E;

  serial_program_cmd_decoder #(
    .PAGE_WAIT_CYC  (600),
    .EE_WAIT_CYC    (EE_WAIT),
    .ERASE_WAIT_CYC (16400),
    .SIGNATURE      (SIG),
    .CAL_BYTE       (CAL)
  ) dut (
    .core_clk_i     (core_clk),
    .rst_n_i        (rst_n),
    .prog_reset_n_i (prog_reset_n),
    .sck_i          (sck),
    .mosi_i         (mosi),
    .miso_o         (miso),
    .prog_enabled_o (prog_enabled),
    .busy_o         (busy)
  );

  isp_programmer prog (
    .sck_o  (sck),
    .mosi_o (mosi),
    .miso_i (miso)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Sends an instruction and returns the fourth answer byte.
  task automatic rd(input logic [31:0] c, output logic [7:0] d);
    logic [31:0] r;
    prog.xfer(c, r);
    d = r[7:0];
  endtask

  task automatic wait_idle(input int max);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < max) begin
      @(negedge core_clk);
      n++;
    end
    `CHECK_EQ(busy, 1'b0, "busy stuck")
  endtask

  task automatic set_pin(input logic v);
    @(negedge core_clk);
    prog_reset_n = v;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic [7:0]  d;
    prog.xfer(32'hAC53_0000, r);
    `CHECK_EQ(prog_enabled, 1'b0, "enable with pin high")
    set_pin(1'b0);
    rd(32'h5000_0000, d);
    `CHECK_EQ(d, 8'h00, "read before enable")
    prog.xfer(32'hC003_5A3C, r);
    `CHECK_EQ(busy, 1'b0, "write before enable")
  endtask

  task automatic t_enable();
    logic [31:0] r;
    prog.xfer(32'hAC53_0000, r);
    `CHECK_EQ(r[15:8], 8'h53, "enable echo")
    `CHECK_EQ(prog_enabled, 1'b1, "enable accepted")
  endtask

  task automatic t_erase();
    logic [31:0] r;
    logic [7:0]  d;
    prog.xfer(32'hAC80_0000, r);
    `CHECK_EQ(busy, 1'b1, "erase busy")
    rd(32'hA003_FF00, d);
    `CHECK_EQ(d, 8'hFF, "eeprom during erase")
    wait_idle(17000);
    rd(32'h2012_3400, d);
    `CHECK_EQ(d, 8'hFF, "flash erased")
    rd(32'hA003_5A00, d);
    `CHECK_EQ(d, 8'hFF, "eeprom erased")
  endtask

  task automatic t_eeprom();
    logic [31:0] r;
    logic [7:0]  d;
    prog.xfer(32'hC003_5A3C, r);
    `CHECK_EQ(busy, 1'b1, "eeprom write busy")
    rd(32'hA003_5A00, d);
    `CHECK_EQ(d, 8'hFF, "poll while writing")
    wait_idle(1000);
    rd(32'hA003_5A00, d);
    `CHECK_EQ(d, 8'h3C, "eeprom readback")
    prog.xfer(32'hC003_5A81, r);
    wait_idle(1000);
    rd(32'hA003_5A00, d);
    `CHECK_EQ(d, 8'h81, "rewrite without erase")
    prog.xfer(32'hC003_5AFF, r);
    repeat (EE_WAIT + 10) @(negedge core_clk);
    `CHECK_EQ(busy, 1'b0, "full wait after FF write")
    rd(32'hA003_5A00, d);
    `CHECK_EQ(d, 8'hFF, "FF rewrite readback")
    rd(32'hA000_5A00, d);
    `CHECK_EQ(d, 8'hFF, "other eeprom address")
  endtask

  task automatic t_page();
    logic [31:0] r;
    logic [7:0]  d;
    prog.xfer(32'h4000_0511, r);
    prog.xfer(32'h4800_0522, r);
    prog.xfer(32'h4C26_8000, r);
    `CHECK_EQ(busy, 1'b1, "page write busy")
    rd(32'h2026_8500, d);
    `CHECK_EQ(d, 8'hFF, "poll page")
    wait_idle(1000);
    rd(32'h2026_8500, d);
    `CHECK_EQ(d, 8'h11, "flash low byte")
    rd(32'h2826_8500, d);
    `CHECK_EQ(d, 8'h22, "flash high byte")
  endtask

  task automatic t_fuse_lock();
    logic [31:0] r;
    logic [7:0]  d;
    prog.xfer(32'hACA0_005C, r);
    rd(32'h5000_0000, d);
    `CHECK_EQ(d, 8'h5C, "low fuse")
    prog.xfer(32'hACA8_00C3, r);
    rd(32'h5808_0000, d);
    `CHECK_EQ(d, 8'hC3, "high fuse")
    prog.xfer(32'hACE0_00F5, r);
    rd(32'h5800_0000, d);
    `CHECK_EQ(d, 8'hF5, "lock bits")
    rd(32'h3000_0200, d);
    `CHECK_EQ(d, SIG[23:16], "signature byte")
    rd(32'h3800_0000, d);
    `CHECK_EQ(d, CAL, "calibration byte")
    prog.xfer(32'hFFFF_FFFF, r);
    rd(32'h5000_0000, d);
    `CHECK_EQ(d, 8'h5C, "unknown opcode")
  endtask

  task automatic t_exit();
    set_pin(1'b1);
    `CHECK_EQ(prog_enabled, 1'b0, "leave programming")
  endtask

  initial begin
    failures     = 0;
    check_count  = 0;
    rst_n        = 1'b0;
    prog_reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    t_refuse();
    t_enable();
    t_erase();
    t_eeprom();
    t_page();
    t_fuse_lock();
    t_exit();
    summarize();
  end

  initial begin
    #1000000;
    failures++;
    summarize();
  end
endmodule
